// ---- logic/lve_map.svh ----
`ifndef LVE_MAP_SVH
`define LVE_MAP_SVH
// How it works
// - debug: fetch/general-detect fault, others trap
// - debug pushes no code, causes logged
// - fault points at insn, trap after
// - pin edge or controller message raises 2
// - nmi taken at boundary, next pointer
// - one-byte breakpoint traps vector 3 cleanly
// - software interrupt immediate 3 also breakpoints
// - overflow check traps 4 when flag set
// - add/sub update overflow and carry flags
// - bounds check out of range faults 5
// - invalid opcode faults 6, reserved D6/F1 excepted
// - illegal operand type faults 6
// - missing feature bit faults packed/simd insns
// - emulation flag faults packed/simd, some exempt
// - ext-state-save enable clear faults simd
// - simd fp exception unenabled becomes 6
// - guaranteed-undefined insn faults, points at itself
// - lock prefix on unlockable/non-memory faults
// - system segment insns fault in real/v86
// - resume-from-sysmgmt faults outside that mode
// - fault only when the insn retires
// - opcodes D6 and F1 raise nothing
// - invalid opcode: no code, points at insn

// ---------------------------------------------------------------------
// vectors and opcodes
// ---------------------------------------------------------------------
`define LVE_VEC_DEBUG    8'h01
`define LVE_VEC_NMI      8'h02
`define LVE_VEC_BRKPT    8'h03
`define LVE_VEC_OVFL     8'h04
`define LVE_VEC_BOUND    8'h05
`define LVE_VEC_INVOP    8'h06
`define LVE_OPC_RSVD_A   8'hD6
`define LVE_OPC_RSVD_B   8'hF1
`define LVE_IMM_BRKPT    8'h03

// ---------------------------------------------------------------------
// register offsets, bit positions, reset values
// ---------------------------------------------------------------------
`define LVE_ADR_CTL      8'h00
`define LVE_ADR_FEAT     8'h04
`define LVE_ADR_FLAGS    8'h08
`define LVE_ADR_DBGST    8'h0C
`define LVE_ADR_LAST     8'h10
`define LVE_CTL_EM       0
`define LVE_CTL_OS_EXT_STATE_SAVE_ENABLE   1
`define LVE_CTL_OSXMM    2
`define LVE_CTL_REAL     3
`define LVE_CTL_V86      4
`define LVE_CTL_SMM      5
`define LVE_FEAT_PACKED  23
`define LVE_FEAT_SIMD    25
`define LVE_FEAT_SIMD2   26
`define LVE_FLG_CF       0
`define LVE_FLG_OF       11
`define LVE_DBG_FETCH    0
`define LVE_DBG_GD       1
`define LVE_DBG_DATA     2
`define LVE_DBG_IO       3
`define LVE_DBG_STEP     4
`define LVE_DBG_TASK     5
`define LVE_DBG_INT1     6
`define LVE_RST_CTL      32'h0000_0000
`define LVE_RST_FEAT     32'h0680_0000
`define LVE_RST_FLAGS    32'h0000_0000
`endif

// ---- logic/lve_pkg.sv ----
package lve_pkg;
  // dispatch state, one-hot
  typedef enum logic [1:0] {
    LVE_IDLE = 2'b01,
    LVE_HOLD = 2'b10
  } lve_st_e;

  // class of the retiring instruction
  typedef enum logic [3:0] {
    LVE_K_PLAIN = 4'h0, LVE_K_ADDSUB = 4'h1, LVE_K_INT1 = 4'h2,
    LVE_K_INT3 = 4'h3, LVE_K_INTN = 4'h4, LVE_K_INTO = 4'h5,
    LVE_K_BOUND = 4'h6, LVE_K_UNDEF = 4'h7, LVE_K_UD2 = 4'h8,
    LVE_K_FARLD = 4'h9, LVE_K_PACKED = 4'hA, LVE_K_SIMD = 4'hB,
    LVE_K_SIMD2 = 4'hC, LVE_K_SYSSEG = 4'hD, LVE_K_RSM = 4'hE
  } lve_kind_e;

  // one retiring instruction as the pipeline describes it
  typedef struct packed {
    lve_kind_e   kind;
    logic [7:0]  opcode;     // primary opcode byte
    logic [7:0]  imm;        // immediate of the software interrupt
    logic        mem_dst;    // operand / destination is memory
    logic        lock;       // bus-lock prefix present
    logic        lockable;   // instruction may be locked
    logic        em_exempt;  // exempt from the emulation check
    logic        fx_exempt;  // exempt from the ext-state check
    logic        simd_fpx;   // would raise a simd fp exception
    logic        is_sub;     // add/sub: subtract
    logic [6:0]  dbg;        // debug conditions, dbg status layout
    logic [31:0] op_a;       // add/sub operand, or bound index
    logic [31:0] op_b;       // add/sub operand, or lower bound
    logic [31:0] op_c;       // upper bound
    logic [31:0] cur_ptr;    // pointer of this instruction
    logic [31:0] next_ptr;   // pointer of the following one
  } lve_retire_s;

  // exception handed to dispatch
  typedef struct packed {
    logic [7:0]  vector;
    logic        is_fault;
    logic        err_valid;
    logic [31:0] ptr;
  } lve_exc_s;

  // complete state of the unit
  typedef struct packed {
    lve_st_e     st;
    logic [31:0] ctl;
    logic [31:0] feat;
    logic [31:0] flags;
    logic [6:0]  dbgst;
    logic        nmi_pend;
    logic        nmi_pin_d;
    logic        wb_ack;
    logic [31:0] wb_dat;
    lve_exc_s    exc;
  } lve_state_s;
endpackage

// ---- logic/lve_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lve_map.svh"
module lve_top
  import lve_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // retirement stream
  input  wire logic        retire_valid_i,
  input  wire lve_retire_s retire_i,
  output logic             retire_ready_o,
  // nonmaskable sources
  input  wire logic        nmi_pin_i,
  input  wire logic        nmi_msg_i,
  // dispatch side
  output logic             exc_valid_o,
  output lve_exc_s         exc_o,
  input  wire logic        exc_ack_i,
  output logic      [31:0] flags_o
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  lve_state_s s_r;       // registered state
  lve_state_s s_nxt;     // next state
  logic       accept;    // retirement taken this cycle
  logic       nmi_evt;   // new nonmaskable request this cycle
  logic       wb_req;    // bus request not yet answered

  assign accept  = retire_valid_i && (s_r.st == LVE_IDLE);
  assign nmi_evt = (nmi_pin_i && !s_r.nmi_pin_d) || nmi_msg_i;
  assign wb_req  = wb_cyc_i && wb_stb_i && !s_r.wb_ack;

  // outputs come straight from state flops
  assign retire_ready_o = (s_r.st == LVE_IDLE);
  assign exc_valid_o    = (s_r.st == LVE_HOLD);
  assign exc_o          = s_r.exc;
  assign wb_ack_o       = s_r.wb_ack;
  assign wb_dat_o       = s_r.wb_dat;
  assign flags_o        = s_r.flags;

  // -------------------------------------------------------------------
  // classification of the retiring instruction
  // -------------------------------------------------------------------
  logic        ud;        // invalid-opcode condition
  logic        bnd;       // bound out of range
  logic        dbg_flt;   // fault-class debug condition
  logic        dbg_trp;   // trap-class debug condition
  logic        bp;        // breakpoint trap
  logic        ovf;       // overflow trap
  logic        em;        // emulation flag
  logic        osfx;      // ext-state-save enable
  logic        osxm;      // simd exception enable
  logic [32:0] sum;       // add/sub result with carry
  logic        of_new;    // signed overflow of add/sub

  // decode looks only at retiring fields and the unit's own registers; wrong-path work never gets here
  always_comb begin
    em   = s_r.ctl[`LVE_CTL_EM];
    osfx = s_r.ctl[`LVE_CTL_OS_EXT_STATE_SAVE_ENABLE];
    osxm = s_r.ctl[`LVE_CTL_OSXMM];
    ud   = 1'b0;
    case (retire_i.kind)
      LVE_K_UNDEF: begin
        // the two reserved bytes run as no-ops
        ud = (retire_i.opcode != `LVE_OPC_RSVD_A)
          && (retire_i.opcode != `LVE_OPC_RSVD_B);
      end
      LVE_K_UD2: begin
        ud = 1'b1;
      end
      LVE_K_FARLD: begin
        ud = !retire_i.mem_dst;
      end
      LVE_K_PACKED: begin
        ud = !s_r.feat[`LVE_FEAT_PACKED]
          || (em && !retire_i.em_exempt);
      end
      LVE_K_SIMD, LVE_K_SIMD2: begin
        ud = ((retire_i.kind == LVE_K_SIMD) ? !s_r.feat[`LVE_FEAT_SIMD]
                                            : !s_r.feat[`LVE_FEAT_SIMD2])
          || (em && !retire_i.em_exempt)
          || (!osfx && !retire_i.fx_exempt)
          || (retire_i.simd_fpx && !osxm);
      end
      LVE_K_SYSSEG: begin
        ud = s_r.ctl[`LVE_CTL_REAL] || s_r.ctl[`LVE_CTL_V86];
      end
      LVE_K_RSM: begin
        ud = !s_r.ctl[`LVE_CTL_SMM];
      end
      default: begin
        ud = 1'b0;
      end
    endcase
    // a lock prefix is legal only on lockable memory destinations
    if (retire_i.lock && (!retire_i.lockable || !retire_i.mem_dst)) begin
      ud = 1'b1;
    end
    // signed compare against bounds held in memory
    bnd = (retire_i.kind == LVE_K_BOUND)
       && (($signed(retire_i.op_a) < $signed(retire_i.op_b))
        || ($signed(retire_i.op_a) > $signed(retire_i.op_c)));
    dbg_flt = retire_i.dbg[`LVE_DBG_FETCH] || retire_i.dbg[`LVE_DBG_GD];
    dbg_trp = retire_i.dbg[`LVE_DBG_DATA] || retire_i.dbg[`LVE_DBG_IO]
           || retire_i.dbg[`LVE_DBG_STEP] || retire_i.dbg[`LVE_DBG_TASK]
           || (retire_i.kind == LVE_K_INT1);
    bp  = (retire_i.kind == LVE_K_INT3)
       || ((retire_i.kind == LVE_K_INTN) && (retire_i.imm == `LVE_IMM_BRKPT));
    ovf = (retire_i.kind == LVE_K_INTO) && s_r.flags[`LVE_FLG_OF];
    // carry out of add doubles as borrow of subtract
    if (retire_i.is_sub) begin
      sum    = {1'b0, retire_i.op_a} - {1'b0, retire_i.op_b};
      of_new = (retire_i.op_a[31] != retire_i.op_b[31]) && (sum[31] != retire_i.op_a[31]);
    end else begin
      sum    = {1'b0, retire_i.op_a} + {1'b0, retire_i.op_b};
      of_new = (retire_i.op_a[31] == retire_i.op_b[31]) && (sum[31] != retire_i.op_a[31]);
    end
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  logic [6:0] dbg_set;   // debug causes to log
  logic [6:0] dbg_clr;   // software write-one-to-clear

  always_comb begin
    s_nxt           = s_r;
    dbg_set         = 7'h00;
    dbg_clr         = 7'h00;
    s_nxt.nmi_pin_d = nmi_pin_i;
    // ---- register bus: one wait state, ack for one cycle ----
    s_nxt.wb_ack = wb_req;
    if (wb_req) begin
      // unmapped offsets read zero and ignore writes
      if (wb_adr_i == `LVE_ADR_CTL) begin
        s_nxt.wb_dat = s_r.ctl;
      end else if (wb_adr_i == `LVE_ADR_FEAT) begin
        s_nxt.wb_dat = s_r.feat;
      end else if (wb_adr_i == `LVE_ADR_FLAGS) begin
        s_nxt.wb_dat = s_r.flags;
      end else if (wb_adr_i == `LVE_ADR_DBGST) begin
        s_nxt.wb_dat = {25'h0, s_r.dbgst};
      end else if (wb_adr_i == `LVE_ADR_LAST) begin
        s_nxt.wb_dat = {22'h0, s_r.exc.err_valid, s_r.exc.is_fault, s_r.exc.vector};
      end else begin
        s_nxt.wb_dat = 32'h0;
      end
    end
    // writes land on the edge that shows ack to the master, never earlier, so
    // a cycle that is dropped before its answer changes nothing
    if (wb_cyc_i && wb_stb_i && wb_we_i && s_r.wb_ack) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          if (wb_adr_i == `LVE_ADR_CTL) begin
            s_nxt.ctl[i*8 +: 8] = wb_dat_i[i*8 +: 8];
          end else if (wb_adr_i == `LVE_ADR_FEAT) begin
            s_nxt.feat[i*8 +: 8] = wb_dat_i[i*8 +: 8];
          end else if (wb_adr_i == `LVE_ADR_FLAGS) begin
            s_nxt.flags[i*8 +: 8] = wb_dat_i[i*8 +: 8];
          end
        end
      end
      if ((wb_adr_i == `LVE_ADR_DBGST) && wb_sel_i[0]) begin
        dbg_clr = wb_dat_i[6:0];
      end
    end
    // ---- nonmaskable request waits for a boundary ----
    if (nmi_evt) begin
      s_nxt.nmi_pend = 1'b1;
    end
    // ---- dispatch handshake ----
    case (s_r.st)
      LVE_IDLE: begin
        if (accept) begin
          s_nxt.exc.err_valid = 1'b0;
          s_nxt.st            = LVE_HOLD;
          if (dbg_flt) begin
            // fetch breakpoint beats decode: insn never ran
            s_nxt.exc.vector   = `LVE_VEC_DEBUG;
            s_nxt.exc.is_fault = 1'b1;
            s_nxt.exc.ptr      = retire_i.cur_ptr;
            dbg_set            = retire_i.dbg & 7'h03;
          end else if (ud) begin
            s_nxt.exc.vector   = `LVE_VEC_INVOP;
            s_nxt.exc.is_fault = 1'b1;
            s_nxt.exc.ptr      = retire_i.cur_ptr;
          end else if (bnd) begin
            // operands untouched so the check restarts
            s_nxt.exc.vector   = `LVE_VEC_BOUND;
            s_nxt.exc.is_fault = 1'b1;
            s_nxt.exc.ptr      = retire_i.cur_ptr;
          end else begin
            // instruction completes; traps point past it
            s_nxt.exc.is_fault = 1'b0;
            s_nxt.exc.ptr      = retire_i.next_ptr;
            if (retire_i.kind == LVE_K_ADDSUB) begin
              s_nxt.flags[`LVE_FLG_CF] = sum[32];
              s_nxt.flags[`LVE_FLG_OF] = of_new;
            end
            if (dbg_trp) begin
              s_nxt.exc.vector = `LVE_VEC_DEBUG;
              dbg_set          = retire_i.dbg & 7'h3C;
              dbg_set[`LVE_DBG_INT1] = (retire_i.kind == LVE_K_INT1);
            end else if (bp) begin
              s_nxt.exc.vector = `LVE_VEC_BRKPT;
            end else if (ovf) begin
              s_nxt.exc.vector = `LVE_VEC_OVFL;
            end else if (s_r.nmi_pend || nmi_evt) begin
              s_nxt.exc.vector = `LVE_VEC_NMI;
              s_nxt.nmi_pend   = 1'b0;
            end else begin
              s_nxt.st = LVE_IDLE;
              s_nxt.exc = s_r.exc;
            end
          end
        end
      end
      LVE_HOLD: begin
        // retirement stalls until dispatch takes the exception
        if (exc_ack_i) begin
          s_nxt.st = LVE_IDLE;
        end
      end
      default: begin
        s_nxt.st = LVE_IDLE;
      end
    endcase
    // a cause logged in the clearing cycle survives
    s_nxt.dbgst = (s_r.dbgst & ~dbg_clr) | dbg_set;
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r       <= '0;
      s_r.st    <= LVE_IDLE;
      s_r.ctl   <= `LVE_RST_CTL;
      s_r.feat  <= `LVE_RST_FEAT;
      s_r.flags <= `LVE_RST_FLAGS;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  property p_ud2_self;
    @(posedge clk_i) disable iff (rst_i)
    accept && (retire_i.kind == LVE_K_UD2) && !dbg_flt |=>
      exc_valid_o && (exc_o.vector == `LVE_VEC_INVOP) && exc_o.is_fault
      && (exc_o.ptr == $past(retire_i.cur_ptr));
  endproperty
  a_ud2_self: assert property (p_ud2_self) else $error("ud2 not faulted");

  property p_rsvd_quiet;
    @(posedge clk_i) disable iff (rst_i)
    accept && (retire_i.kind == LVE_K_UNDEF) && !retire_i.lock && (retire_i.dbg == 7'h00)
      && (retire_i.opcode == `LVE_OPC_RSVD_A) |=>
      !(exc_valid_o && (exc_o.vector == `LVE_VEC_INVOP));
  endproperty
  a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("reserved byte faulted");

  property p_no_errcode;
    @(posedge clk_i) disable iff (rst_i)
    exc_valid_o |-> !exc_o.err_valid;
  endproperty
  a_no_errcode: assert property (p_no_errcode) else $error("error code flagged");

  property p_retire_cause;
    @(posedge clk_i) disable iff (rst_i)
    $rose(exc_valid_o) |-> $past(accept);
  endproperty
  a_retire_cause: assert property (p_retire_cause) else $error("exception w/o retire");

  property p_fault_ptr;
    @(posedge clk_i) disable iff (rst_i)
    $rose(exc_valid_o) && exc_o.is_fault |-> exc_o.ptr == $past(retire_i.cur_ptr);
  endproperty
  a_fault_ptr: assert property (p_fault_ptr) else $error("fault pointer wrong");

  property p_trap_ptr;
    @(posedge clk_i) disable iff (rst_i)
    $rose(exc_valid_o) && !exc_o.is_fault |-> exc_o.ptr == $past(retire_i.next_ptr);
  endproperty
  a_trap_ptr: assert property (p_trap_ptr) else $error("trap pointer wrong");

  property p_nmi_kept;
    @(posedge clk_i) disable iff (rst_i)
    nmi_evt |=> s_r.nmi_pend || (exc_valid_o && (exc_o.vector == `LVE_VEC_NMI));
  endproperty
  a_nmi_kept: assert property (p_nmi_kept) else $error("nmi request lost");

  property p_ovf_flag;
    @(posedge clk_i) disable iff (rst_i)
    $rose(exc_valid_o) && (exc_o.vector == `LVE_VEC_OVFL) |->
      $past(s_r.flags[`LVE_FLG_OF]) && !exc_o.is_fault;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow trap w/o flag");

  property p_dbg_logged;
    @(posedge clk_i) disable iff (rst_i)
    $rose(exc_valid_o) && (exc_o.vector == `LVE_VEC_DEBUG) |-> s_r.dbgst != 7'h00;
  endproperty
  a_dbg_logged: assert property (p_dbg_logged) else $error("debug cause not logged");

  // an index below the lower bound must restart through vector 5
  property p_bound_low;
    @(posedge clk_i) disable iff (rst_i)
    accept && (retire_i.kind == LVE_K_BOUND) && !retire_i.lock && (retire_i.dbg[1:0] == 2'h0)
      && ($signed(retire_i.op_a) < $signed(retire_i.op_b)) |=>
      exc_valid_o && (exc_o.vector == `LVE_VEC_BOUND) && exc_o.is_fault;
  endproperty
  a_bound_low: assert property (p_bound_low) else $error("bound fault missing");

  // the one-byte breakpoint completes and points past itself
  property p_brk_trap;
    @(posedge clk_i) disable iff (rst_i)
    accept && (retire_i.kind == LVE_K_INT3) && !retire_i.lock && (retire_i.dbg == 7'h00) |=>
      exc_valid_o && (exc_o.vector == `LVE_VEC_BRKPT) && !exc_o.is_fault;
  endproperty
  a_brk_trap: assert property (p_brk_trap) else $error("breakpoint trap missing");

  // the one-byte debug interrupt is a trap unless a fetch or general-detect fault beats it
  property p_int1_trap;
    @(posedge clk_i) disable iff (rst_i)
    accept && (retire_i.kind == LVE_K_INT1) && !retire_i.lock && (retire_i.dbg[1:0] == 2'h0) |=>
      exc_valid_o && (exc_o.vector == `LVE_VEC_DEBUG) && !exc_o.is_fault;
  endproperty
  a_int1_trap: assert property (p_int1_trap) else $error("debug trap missing");

  // emulation mode turns every non-exempt packed-integer op into vector 6
  property p_em_packed;
    @(posedge clk_i) disable iff (rst_i)
    accept && (retire_i.kind == LVE_K_PACKED) && s_r.ctl[`LVE_CTL_EM] && !retire_i.em_exempt
      && (retire_i.dbg[1:0] == 2'h0) |=>
      exc_valid_o && (exc_o.vector == `LVE_VEC_INVOP) && exc_o.is_fault;
  endproperty
  a_em_packed: assert property (p_em_packed) else $error("emulation fault missing");

  // a fault leaves the flags alone; a bus write landing beside it is exempt
  property p_fault_flags;
    @(posedge clk_i) disable iff (rst_i)
    $rose(exc_valid_o) && exc_o.is_fault && !$past(wb_ack_o) |-> flags_o == $past(flags_o);
  endproperty
  a_fault_flags: assert property (p_fault_flags) else $error("fault changed flags");

  // the nonmaskable vector is a trap and needs a request behind it
  property p_nmi_trap;
    @(posedge clk_i) disable iff (rst_i)
    $rose(exc_valid_o) && (exc_o.vector == `LVE_VEC_NMI) |->
      !exc_o.is_fault && ($past(s_r.nmi_pend) || $past(nmi_evt));
  endproperty
  a_nmi_trap: assert property (p_nmi_trap) else $error("nmi without request");

  // ack is a single pulse so a held strobe cannot double a write
  property p_wb_pulse;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_wb_pulse: assert property (p_wb_pulse) else $error("ack longer than one cycle");

endmodule
`default_nettype wire

// ---- tb/lve_nmi_src.sv ----
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// nonmaskable sources: external pin and controller message
// ---------------------------------------------------------------
module lve_nmi_src (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_req_i,  // raise the pin for a few cycles
  input  wire logic msg_req_i,  // send one controller request
  output logic      nmi_pin_o,
  output logic      nmi_msg_o
);
  logic [1:0] hold_r;  // pin stays up three cycles so the edge is seen

  // pin is a level that falls again; the message is a single pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_r    <= 2'h0;
      nmi_pin_o <= 1'b0;
      nmi_msg_o <= 1'b0;
    end else begin
      hold_r    <= pin_req_i ? 2'h3 : ((hold_r != 2'h0) ? hold_r - 2'h1 : 2'h0);
      nmi_pin_o <= pin_req_i || (hold_r > 2'h1);
      nmi_msg_o <= msg_req_i;
    end
  end
endmodule
`default_nettype wire

// ---- tb/lve_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lve_map.svh"
module lve_tb_top
  import lve_pkg::*;
;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, flags_o, q;
  logic        retire_valid_i, retire_ready_o, exc_valid_o, exc_ack_i;
  logic        nmi_pin_i, nmi_msg_i, pin_req, msg_req;
  lve_retire_s retire_i, r;
  lve_exc_s    exc_o;
  int          errors, tests_run;
  // kinds gated by capability bits, and the bit that enables each
  lve_kind_e   ks [3] = '{LVE_K_PACKED, LVE_K_SIMD, LVE_K_SIMD2};
  logic [31:0] fb [3] = '{32'h0080_0000, 32'h0200_0000, 32'h0400_0000};

  lve_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .retire_valid_i(retire_valid_i),
    .retire_i(retire_i), .retire_ready_o(retire_ready_o), .nmi_pin_i(nmi_pin_i),
    .nmi_msg_i(nmi_msg_i), .exc_valid_o(exc_valid_o), .exc_o(exc_o),
    .exc_ack_i(exc_ack_i), .flags_o(flags_o));
  lve_nmi_src nsrc (.clk_i(clk_i), .rst_i(rst_i), .pin_req_i(pin_req),
    .msg_req_i(msg_req), .nmi_pin_o(nmi_pin_i), .nmi_msg_o(nmi_msg_i));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // classic cycle: hold until ack is sampled high at an edge, take data and
  // release at that same edge; only the watchdog ends a wait that never ends
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // default descriptor: memory operand, pointers easy to tell apart
  function automatic lve_retire_s mk(input lve_kind_e k);
    lve_retire_s d;
    d = '0;
    d.kind = k;
    d.mem_dst = 1'b1;
    d.cur_ptr = 32'h0000_1000;
    d.next_ptr = 32'h0000_1004;
    return d;
  endfunction

  // retire one instruction; v of zero means no exception expected
  task automatic run(input lve_retire_s d, input logic [7:0] v, input logic f);
    @(posedge clk_i);
    retire_valid_i <= 1'b1;
    retire_i <= d;
    @(posedge clk_i);
    retire_valid_i <= 1'b0;
    #1;
    chk("exc_valid", 32'(v != 8'h00), 32'(exc_valid_o));
    chk("ready", 32'(v == 8'h00), 32'(retire_ready_o));
    if (v != 8'h00) begin
      chk("vector", 32'(v), 32'(exc_o.vector));
      chk("is_fault", 32'(f), 32'(exc_o.is_fault));
      chk("err_valid", 32'h0, 32'(exc_o.err_valid));
      chk("ptr", f ? d.cur_ptr : d.next_ptr, exc_o.ptr);
      @(posedge clk_i);
      exc_ack_i <= 1'b1;
      @(posedge clk_i);
      exc_ack_i <= 1'b0;
      #1;
      chk("exc_drop", 32'h0, 32'(exc_valid_o));
    end
  endtask

  task automatic pulse(input logic pin);
    @(posedge clk_i);
    pin_req <= pin;
    msg_req <= !pin;
    @(posedge clk_i);
    pin_req <= 1'b0;
    msg_req <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and test sequence
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    give_verdict();
  end

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, retire_valid_i, exc_ack_i, pin_req, msg_req} = '0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    retire_i = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("flags_o", 32'h0, flags_o);
    rdc("ctl", `LVE_ADR_CTL, 32'h0);
    rdc("feat", `LVE_ADR_FEAT, 32'h0680_0000);
    rdc("unmapped", 8'h40, 32'h0);
    $display("test done: reset");
    for (int i = 0; i < 7; i++) begin
      // the one-byte debug interrupt is an instruction kind, not a condition bit
      r = mk((i == 6) ? LVE_K_INT1 : LVE_K_PLAIN);
      r.dbg = 7'(1 << i);
      run(r, 8'h01, i < 2);
      rdc("dbgst", `LVE_ADR_DBGST, 32'(1 << i));
      rdc("last", `LVE_ADR_LAST, {23'h0, i < 2, 8'h01});
      wb(1'b1, `LVE_ADR_DBGST, 32'h7F);
    end
    r.dbg = 7'h05;
    run(r, 8'h01, 1'b1);
    rdc("dbgst", `LVE_ADR_DBGST, 32'h1);
    wb(1'b1, `LVE_ADR_DBGST, 32'h7F);
    $display("test done: debug");
    r = mk(LVE_K_ADDSUB);
    r.is_sub = 1'b1;
    r.op_a = 32'h8000_0000;
    r.op_b = 32'h0000_0001;
    run(r, 8'h00, 1'b0);
    chk("flags_o", 32'h0000_0800, flags_o);
    run(mk(LVE_K_INTO), 8'h04, 1'b0);
    run(mk(LVE_K_INT3), 8'h03, 1'b0);
    chk("flags_o", 32'h0000_0800, flags_o);
    r = mk(LVE_K_INTN);
    r.imm = 8'h03;
    run(r, 8'h03, 1'b0);
    r = mk(LVE_K_ADDSUB);
    r.op_a = 32'hFFFF_FFFF;
    r.op_b = 32'h0000_0001;
    run(r, 8'h00, 1'b0);
    chk("flags_o", 32'h0000_0001, flags_o);
    run(mk(LVE_K_INTO), 8'h00, 1'b0);
    r = mk(LVE_K_BOUND);
    r.op_a = 32'hFFFF_FFFF;
    r.op_c = 32'h0000_000A;
    run(r, 8'h05, 1'b1);
    r.op_a = 32'h0000_000A;
    run(r, 8'h00, 1'b0);
    $display("test done: traps and bounds");
    // an undefined descriptor offered without valid must stay silent
    @(posedge clk_i);
    retire_i <= mk(LVE_K_UD2);
    repeat (3) @(posedge clk_i);
    #1;
    chk("exc_valid", 32'h0, 32'(exc_valid_o));
    run(mk(LVE_K_UD2), 8'h06, 1'b1);
    r = mk(LVE_K_UNDEF);
    r.opcode = 8'hFF;
    run(r, 8'h06, 1'b1);
    r.opcode = 8'hD6;
    run(r, 8'h00, 1'b0);
    r.opcode = 8'hF1;
    run(r, 8'h00, 1'b0);
    r = mk(LVE_K_FARLD);
    run(r, 8'h00, 1'b0);
    r.mem_dst = 1'b0;
    run(r, 8'h06, 1'b1);
    r = mk(LVE_K_PLAIN);
    r.lock = 1'b1;
    run(r, 8'h06, 1'b1);
    r.lockable = 1'b1;
    r.mem_dst = 1'b0;
    run(r, 8'h06, 1'b1);
    r.mem_dst = 1'b1;
    run(r, 8'h00, 1'b0);
    wb(1'b1, `LVE_ADR_CTL, 32'h0000_0006);
    foreach (ks[j]) begin
      wb(1'b1, `LVE_ADR_FEAT, 32'h0680_0000 ^ fb[j]);
      run(mk(ks[j]), 8'h06, 1'b1);
    end
    wb(1'b1, `LVE_ADR_FEAT, 32'h0680_0000);
    foreach (ks[j]) run(mk(ks[j]), 8'h00, 1'b0);
    wb(1'b1, `LVE_ADR_CTL, 32'h0000_0007);
    r = mk(LVE_K_PACKED);
    run(r, 8'h06, 1'b1);
    r.em_exempt = 1'b1;
    run(r, 8'h00, 1'b0);
    run(mk(LVE_K_SIMD), 8'h06, 1'b1);
    wb(1'b1, `LVE_ADR_CTL, 32'h0000_0004);
    r = mk(LVE_K_SIMD);
    run(r, 8'h06, 1'b1);
    r.fx_exempt = 1'b1;
    run(r, 8'h00, 1'b0);
    run(mk(LVE_K_PACKED), 8'h00, 1'b0);
    wb(1'b1, `LVE_ADR_CTL, 32'h0000_0002);
    r = mk(LVE_K_SIMD);
    r.simd_fpx = 1'b1;
    run(r, 8'h06, 1'b1);
    wb(1'b1, `LVE_ADR_CTL, 32'h0000_0006);
    run(r, 8'h00, 1'b0);
    wb(1'b1, `LVE_ADR_CTL, 32'h0000_0008);
    run(mk(LVE_K_SYSSEG), 8'h06, 1'b1);
    wb(1'b1, `LVE_ADR_CTL, 32'h0000_0010);
    run(mk(LVE_K_SYSSEG), 8'h06, 1'b1);
    wb(1'b1, `LVE_ADR_CTL, 32'h0000_0020);
    rdc("ctl", `LVE_ADR_CTL, 32'h0000_0020);
    run(mk(LVE_K_SYSSEG), 8'h00, 1'b0);
    run(mk(LVE_K_RSM), 8'h00, 1'b0);
    wb(1'b1, `LVE_ADR_CTL, 32'h0000_0000);
    run(mk(LVE_K_RSM), 8'h06, 1'b1);
    $display("test done: invalid opcode");
    pulse(1'b1);
    run(mk(LVE_K_UD2), 8'h06, 1'b1);
    run(mk(LVE_K_PLAIN), 8'h02, 1'b0);
    run(mk(LVE_K_PLAIN), 8'h00, 1'b0);
    pulse(1'b0);
    run(mk(LVE_K_PLAIN), 8'h02, 1'b0);
    $display("test done: nmi");
    give_verdict();
  end
endmodule
`default_nettype wire
